// [pkg/limiter_pkg.sv]
// Operation
// - The block trips whenever the limiter temperature is at or above the active setpoint.
// - A probe open, probe short, internal component fault or supply fault trips it as well.
// - Entering the trip removes heater power in the same cycle, with no delay or filtering.
// - A clear request is ignored while overtemperature or any fault remains active.
// - A clear request may come from the front button, the local interface or a remote port.
// - With self-rearm on, no heater current at the overtemperature and no fault seen during the trip, it clears itself.
// - With self-rearm off or current seen at the overtemperature, it waits for a clear.
// - While the safety output is off the main heater output is forced off.
// - The main output may be on only with the sensor connected and below the setpoint.
// - A new setpoint is taken only if confirmed within 30 seconds, otherwise it is dropped.
package limiter_pkg;

   localparam int TEMP_W = 12;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h1;
   localparam logic [ADDR_W-1:0] REG_SETPOINT = 4'h2;
   localparam logic [ADDR_W-1:0] REG_SP_ENTRY = 4'h3;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h4;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h5;

   localparam int CTRL_REARM_BIT = 0;
   localparam int CTRL_UICLR_BIT = 1;

   localparam int ST_TRIPPED_BIT = 0;
   localparam int ST_CURFLAG_BIT = 1;
   localparam int ST_OTSEEN_BIT  = 2;
   localparam int ST_FLTSEEN_BIT = 3;
   localparam int ST_PENDING_BIT = 4;
   localparam int ST_SAFETY_BIT  = 5;
   localparam int ST_MAIN_BIT    = 6;

   localparam int IRQ_W        = 4;
   localparam int IRQ_TRIP_BIT = 0;
   localparam int IRQ_CLR_BIT  = 1;
   localparam int IRQ_SPOK_BIT = 2;
   localparam int IRQ_SPEXP_BIT = 3;

   localparam logic [TEMP_W-1:0] SP_RESET = 12'h0C8;
   localparam logic [IRQ_W-1:0]  IRQ_MASK_RESET = 4'h0;

   localparam longint CLK_HZ           = 25_000_000;
   localparam longint CONFIRM_WINDOW_S = 30;
   localparam longint CONFIRM_CYC      = CONFIRM_WINDOW_S * CLK_HZ;

   typedef enum logic [1:0] {
      ST_ARMED   = 2'b01,
      ST_TRIPPED = 2'b10
   } trip_state_t;

endpackage

// [logic/pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; the output moves only when stages two and three agree.
module pin_sync (
   // Clock and reset
   input  wire logic CLK_I,
   input  wire logic RST_I,
   // Pin and synchronised level
   input  wire logic pin_i,
   output var  logic level_o
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic lvl_ff;
   wire  agree = (s2_ff == s3_ff);

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         s1_ff  <= 1'b0;
         s2_ff  <= 1'b0;
         s3_ff  <= 1'b0;
         lvl_ff <= 1'b0;
      end else begin
         s1_ff  <= pin_i;
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         lvl_ff <= agree ? s3_ff : lvl_ff;
      end
   end

   assign level_o = lvl_ff;
endmodule
`default_nettype wire

// [logic/setpoint_confirm.sv]
`timescale 1ns/1ns
`default_nettype none
// Holds the active limit setpoint and a pending entry that waits for confirmation.
module setpoint_confirm
   import limiter_pkg::*;
#(
   parameter longint CONFIRM_CYCLES = CONFIRM_CYC
) (
   // Clock and reset
   input  wire logic              CLK_I,
   input  wire logic              RST_I,
   // Entry and confirmation
   input  wire logic              load_i,
   input  wire logic [TEMP_W-1:0] value_i,
   input  wire logic              confirm_i,
   // Results
   output var  logic [TEMP_W-1:0] sp_o,
   output var  logic              pending_o,
   output var  logic              commit_o,
   output var  logic              expire_o
);
   localparam int CNT_W = $clog2(CONFIRM_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CONFIRM_CYCLES);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   logic [TEMP_W-1:0] sp_ff;
   logic [TEMP_W-1:0] entry_ff;
   logic              pend_ff;
   logic [CNT_W-1:0]  cnt_ff;

   wire commit = pend_ff & confirm_i & ~load_i;
   wire expire = pend_ff & ~confirm_i & ~load_i & (cnt_ff == CNT_ONE);

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sp_ff    <= SP_RESET;
         entry_ff <= '0;
         pend_ff  <= 1'b0;
         cnt_ff   <= '0;
      end else begin
         sp_ff    <= commit ? entry_ff : sp_ff;
         entry_ff <= load_i ? value_i : entry_ff;
         pend_ff  <= load_i | (pend_ff & ~commit & ~expire);
         cnt_ff   <= load_i ? CNT_LOAD : (pend_ff ? cnt_ff - CNT_ONE : cnt_ff);
      end
   end

   assign sp_o      = sp_ff;
   assign pending_o = pend_ff;
   assign commit_o  = commit;
   assign expire_o  = expire;

   a_sp_discard_old: assert property (@(posedge CLK_I) disable iff (RST_I)
      expire |=> (sp_ff == $past(sp_ff)) && !pend_ff)
      else $error("setpoint changed on expiry");
   a_sp_commit_new: assert property (@(posedge CLK_I) disable iff (RST_I)
      commit |=> (sp_ff == $past(entry_ff)) && !pend_ff)
      else $error("confirmed setpoint not taken");
endmodule
`default_nettype wire

// [logic/overtemp_safety_trip_latch.sv]
`timescale 1ns/1ns
`default_nettype none
// Redundant overtemperature cut-out for the heater, with latched trip and interlock.
module overtemp_safety_trip_latch
   import limiter_pkg::*;
#(
   parameter longint CONFIRM_CYCLES = CONFIRM_CYC
) (
   // Clock and reset
   input  wire logic              CLK_I,
   input  wire logic              RST_I,
   // Sensing front end, same clock
   input  wire logic [TEMP_W-1:0] TEMP_I,
   input  wire logic              PROBE_OPEN_I,
   input  wire logic              PROBE_SHORT_I,
   input  wire logic              COMP_FAULT_I,
   input  wire logic              SUPPLY_FAULT_I,
   input  wire logic              HEAT_CURRENT_I,
   // Normal controller request and remote clear, same clock
   input  wire logic              CTRL_REQ_I,
   input  wire logic              REMOTE_CLR_I,
   // Front panel buttons, asynchronous pins
   input  wire logic              CLR_BTN_I,
   input  wire logic              CONFIRM_BTN_I,
   // Register port
   input  wire logic [ADDR_W-1:0] ADDR_I,
   input  wire logic [DATA_W-1:0] WDATA_I,
   input  wire logic              WR_I,
   input  wire logic              RD_I,
   output var  logic [DATA_W-1:0] RDATA_O,
   // Outputs to the heater switches
   output var  logic              SAFETY_OUT_O,
   output var  logic              MAIN_OUT_O,
   output var  logic              TRIPPED_O,
   // Interrupt
   output var  logic              IRQ_O
);

   trip_state_t       state_ff;
   trip_state_t       nxt_state;
   logic              rearm_en_ff;
   logic              cur_flag_ff;
   logic              ot_seen_ff;
   logic              flt_seen_ff;
   logic [IRQ_W-1:0]  irq_stat_ff;
   logic [IRQ_W-1:0]  irq_mask_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic              clr_lvl_ff;
   logic              cfm_lvl_ff;
   logic              clr_lvl;
   logic              cfm_lvl;
   logic [TEMP_W-1:0] sp_active;
   logic              sp_pending;
   logic              sp_commit;
   logic              sp_expire;

   // Button pins are synchronised before any edge is taken.
   pin_sync u_clr_sync (
      .CLK_I   (CLK_I),
      .RST_I   (RST_I),
      .pin_i   (CLR_BTN_I),
      .level_o (clr_lvl)
   );

   pin_sync u_cfm_sync (
      .CLK_I   (CLK_I),
      .RST_I   (RST_I),
      .pin_i   (CONFIRM_BTN_I),
      .level_o (cfm_lvl)
   );

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         clr_lvl_ff <= 1'b0;
         cfm_lvl_ff <= 1'b0;
      end else begin
         clr_lvl_ff <= clr_lvl;
         cfm_lvl_ff <= cfm_lvl;
      end
   end

   wire clr_btn_pulse = clr_lvl & ~clr_lvl_ff;
   wire cfm_btn_pulse = cfm_lvl & ~cfm_lvl_ff;

   // Register decode.
   wire wr_ctrl  = WR_I & (ADDR_I == REG_CTRL);
   wire wr_entry = WR_I & (ADDR_I == REG_SP_ENTRY);
   wire wr_mask  = WR_I & (ADDR_I == REG_IRQ_MASK);
   wire rd_stat  = RD_I & (ADDR_I == REG_IRQ_STAT);

   setpoint_confirm #(
      .CONFIRM_CYCLES (CONFIRM_CYCLES)
   ) u_setpoint (
      .CLK_I     (CLK_I),
      .RST_I     (RST_I),
      .load_i    (wr_entry),
      .value_i   (WDATA_I[TEMP_W-1:0]),
      .confirm_i (cfm_btn_pulse),
      .sp_o      (sp_active),
      .pending_o (sp_pending),
      .commit_o  (sp_commit),
      .expire_o  (sp_expire)
   );

   wire overtemp  = (TEMP_I >= sp_active);
   wire fault_any = PROBE_OPEN_I | PROBE_SHORT_I | COMP_FAULT_I | SUPPLY_FAULT_I;
   wire sensor_ok = ~PROBE_OPEN_I & ~PROBE_SHORT_I;
   wire trip_cond = overtemp | fault_any;

   wire armed   = (state_ff == ST_ARMED);
   wire tripped = (state_ff == ST_TRIPPED);

   wire ui_clr  = wr_ctrl & WDATA_I[CTRL_UICLR_BIT];
   wire clr_req = clr_btn_pulse | ui_clr | REMOTE_CLR_I;
   wire auto_clr = rearm_en_ff & ot_seen_ff & ~flt_seen_ff & ~cur_flag_ff;
   wire release_trip = tripped & ~trip_cond & (clr_req | auto_clr);
   wire enter_trip   = armed & trip_cond;

   always_comb begin
      case (state_ff)
         ST_ARMED: begin
            nxt_state = trip_cond ? ST_TRIPPED : ST_ARMED;
         end
         ST_TRIPPED: begin
            nxt_state = release_trip ? ST_ARMED : ST_TRIPPED;
         end
         default: begin
            nxt_state = ST_TRIPPED;
         end
      endcase
   end

   wire in_ot_trip   = overtemp & (enter_trip | (tripped & ~release_trip));
   wire nxt_cur_flag = ~release_trip & (cur_flag_ff | (in_ot_trip & HEAT_CURRENT_I));
   wire nxt_ot_seen  = ~release_trip & (ot_seen_ff | in_ot_trip);
   wire nxt_flt_seen = ~release_trip & (flt_seen_ff | (fault_any & (enter_trip | tripped)));

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_ff    <= ST_TRIPPED;
         cur_flag_ff <= 1'b0;
         ot_seen_ff  <= 1'b0;
         flt_seen_ff <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         cur_flag_ff <= nxt_cur_flag;
         ot_seen_ff  <= nxt_ot_seen;
         flt_seen_ff <= nxt_flt_seen;
      end
   end

   // immediate cut
   // The safety path is combinational so a trip cuts power in the cycle it appears.
   wire safety_on = armed & ~trip_cond;
   wire main_on   = safety_on & CTRL_REQ_I & sensor_ok & ~overtemp;

   assign SAFETY_OUT_O = safety_on;
   assign MAIN_OUT_O   = main_on;
   assign TRIPPED_O    = tripped;

   // Interrupt status: an event in the clearing read's cycle survives the clear.
   logic [IRQ_W-1:0] irq_ev;
   always_comb begin
      irq_ev = '0;
      irq_ev[IRQ_TRIP_BIT]  = enter_trip;
      irq_ev[IRQ_CLR_BIT]   = release_trip;
      irq_ev[IRQ_SPOK_BIT]  = sp_commit;
      irq_ev[IRQ_SPEXP_BIT] = sp_expire;
   end

   wire [IRQ_W-1:0] nxt_irq_stat = (rd_stat ? '0 : irq_stat_ff) | irq_ev;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         irq_stat_ff <= '0;
         irq_mask_ff <= IRQ_MASK_RESET;
         rearm_en_ff <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= wr_mask ? WDATA_I[IRQ_W-1:0] : irq_mask_ff;
         rearm_en_ff <= wr_ctrl ? WDATA_I[CTRL_REARM_BIT] : rearm_en_ff;
      end
   end

   assign IRQ_O = |(irq_stat_ff & irq_mask_ff);

   // Read mux; unmapped addresses read zero.
   logic [DATA_W-1:0] ctrl_word;
   logic [DATA_W-1:0] stat_word;
   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      ctrl_word = '0;
      ctrl_word[CTRL_REARM_BIT] = rearm_en_ff;
      stat_word = '0;
      stat_word[ST_TRIPPED_BIT] = tripped;
      stat_word[ST_CURFLAG_BIT] = cur_flag_ff;
      stat_word[ST_OTSEEN_BIT]  = ot_seen_ff;
      stat_word[ST_FLTSEEN_BIT] = flt_seen_ff;
      stat_word[ST_PENDING_BIT] = sp_pending;
      stat_word[ST_SAFETY_BIT]  = safety_on;
      stat_word[ST_MAIN_BIT]    = main_on;
      case (ADDR_I)
         REG_CTRL: begin
            rd_mux = ctrl_word;
         end
         REG_STATUS: begin
            rd_mux = stat_word;
         end
         REG_SETPOINT: begin
            rd_mux = DATA_W'(sp_active);
         end
         REG_IRQ_STAT: begin
            rd_mux = DATA_W'(irq_stat_ff);
         end
         REG_IRQ_MASK: begin
            rd_mux = DATA_W'(irq_mask_ff);
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= RD_I ? rd_mux : '0;
      end
   end

   assign RDATA_O = rdata_ff;

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);

   a_temp_trips_out: assert property (
      overtemp |-> !SAFETY_OUT_O ##1 TRIPPED_O)
      else $error("overtemperature did not trip");

   a_fault_trips: assert property (
      fault_any |-> !SAFETY_OUT_O ##1 TRIPPED_O)
      else $error("fault did not trip");

   a_heater_off_now: assert property (
      (armed && trip_cond) |-> !SAFETY_OUT_O && !MAIN_OUT_O)
      else $error("heater not cut in trip cycle");

   a_no_unsafe_clear: assert property (
      (tripped && trip_cond && clr_req) |=> TRIPPED_O && !SAFETY_OUT_O)
      else $error("trip cleared while unsafe");

   a_clear_sources: assert property (
      (tripped && !trip_cond && clr_req) |=> !TRIPPED_O)
      else $error("clear request not honoured");

   a_self_rearm: assert property (
      (tripped && !trip_cond && rearm_en_ff && ot_seen_ff && !flt_seen_ff && !cur_flag_ff)
      |=> !TRIPPED_O)
      else $error("self rearm did not clear");

   a_hold_manual: assert property (
      (tripped && !clr_req && (!rearm_en_ff || cur_flag_ff)) |=> TRIPPED_O)
      else $error("trip cleared without request");

   a_main_forced_off: assert property (
      !SAFETY_OUT_O |-> !MAIN_OUT_O)
      else $error("main output on while safety off");

   a_main_needs_sensor: assert property (
      MAIN_OUT_O |-> sensor_ok && (TEMP_I < sp_active))
      else $error("main output on without valid sensor");

   a_current_flag: assert property (
      (enter_trip && overtemp && HEAT_CURRENT_I) |=> cur_flag_ff && TRIPPED_O)
      else $error("heater current flag lost");

   a_flag_held: assert property (
      (tripped && cur_flag_ff && !release_trip) |=> cur_flag_ff)
      else $error("heater current flag dropped during trip");

   a_irq_sticky: assert property (
      enter_trip |=> irq_stat_ff[IRQ_TRIP_BIT] && (IRQ_O || !irq_mask_ff[IRQ_TRIP_BIT]))
      else $error("trip event not recorded");

   c_trip_self_rearm: cover property (
      enter_trip && overtemp && !HEAT_CURRENT_I ##[1:50] (release_trip && !clr_req));
   c_button_clear: cover property (
      tripped && !trip_cond && clr_btn_pulse ##1 armed);
   c_sp_commit: cover property (sp_commit);
   c_sp_expire: cover property (sp_expire);

endmodule
`default_nettype wire

// [tb/heater_plant.sv]
`timescale 1ns/1ns
`default_nettype none
// Heater load behind the two switches; current shows one cycle after both close.
module heater_plant (
   // Clock and reset
   input  wire logic CLK_I,
   input  wire logic RST_I,
   // Switch states and load presence
   input  wire logic safety_i,
   input  wire logic main_i,
   input  wire logic load_i,
   // Current sense back to the limiter
   output var  logic current_o
);
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         current_o <= 1'b0;
      end else begin
         current_o <= safety_i & main_i & load_i;
      end
   end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
   $display("unexpected at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
   import limiter_pkg::*;
   logic              CLK_I = 1'b0;
   logic              RST_I = 1'b1;
   logic [TEMP_W-1:0] TEMP_I = 12'h0010;
   logic [3:0]        flt = 4'h0;
   logic              HEAT_CURRENT_I;
   logic              CTRL_REQ_I = 1'b1;
   logic              REMOTE_CLR_I = 1'b0;
   logic              CLR_BTN_I = 1'b0;
   logic              CONFIRM_BTN_I = 1'b0;
   logic [ADDR_W-1:0] ADDR_I = 4'h0;
   logic [DATA_W-1:0] WDATA_I = 16'h0000;
   logic              WR_I = 1'b0;
   logic              RD_I = 1'b0;
   logic [DATA_W-1:0] RDATA_O;
   logic [DATA_W-1:0] rd_val;
   logic              SAFETY_OUT_O;
   logic              MAIN_OUT_O;
   logic              TRIPPED_O;
   logic              IRQ_O;
   logic              load = 1'b1;
   logic              c;
   logic [TEMP_W-1:0] sp = SP_RESET;
   logic [TEMP_W-1:0] t;
   logic [DATA_W-1:0] ctrl_v = 16'h0000;
   int                errors = 0;
   int                n_checks = 0;
   int                seed = 32'hfaf4;

   always #20 CLK_I = ~CLK_I;

   overtemp_safety_trip_latch #(.CONFIRM_CYCLES(50)) dut (
      .CLK_I(CLK_I), .RST_I(RST_I), .TEMP_I(TEMP_I), .PROBE_OPEN_I(flt[0]),
      .PROBE_SHORT_I(flt[1]), .COMP_FAULT_I(flt[2]), .SUPPLY_FAULT_I(flt[3]),
      .HEAT_CURRENT_I(HEAT_CURRENT_I), .CTRL_REQ_I(CTRL_REQ_I), .REMOTE_CLR_I(REMOTE_CLR_I),
      .CLR_BTN_I(CLR_BTN_I), .CONFIRM_BTN_I(CONFIRM_BTN_I), .ADDR_I(ADDR_I),
      .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
      .SAFETY_OUT_O(SAFETY_OUT_O), .MAIN_OUT_O(MAIN_OUT_O), .TRIPPED_O(TRIPPED_O),
      .IRQ_O(IRQ_O));

   heater_plant plant (.CLK_I(CLK_I), .RST_I(RST_I), .safety_i(SAFETY_OUT_O),
      .main_i(MAIN_OUT_O), .load_i(load), .current_o(HEAT_CURRENT_I));

   function automatic logic exp_safe(logic [TEMP_W-1:0] tv, logic [TEMP_W-1:0] s,
                                     logic [3:0] f);
      return (tv < s) && (f == 4'h0);
   endfunction

   task automatic final_report;
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      @(posedge CLK_I);
      WR_I <= 1'b1;
      ADDR_I <= a;
      WDATA_I <= d;
      @(posedge CLK_I);
      WR_I <= 1'b0;
   endtask

   task automatic rd(logic [ADDR_W-1:0] a);
      @(posedge CLK_I);
      RD_I <= 1'b1;
      ADDR_I <= a;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      #1 rd_val = RDATA_O;
   endtask

   task automatic apply(logic [TEMP_W-1:0] tv, logic [3:0] f, logic cr);
      @(posedge CLK_I);
      TEMP_I <= tv;
      flt <= f;
      CTRL_REQ_I <= cr;
      #1;
   endtask

   task automatic wait_trip(logic v);
      int i;
      #1;
      for (i = 0; i < 12 && TRIPPED_O !== v; i++) begin
         @(posedge CLK_I);
         #1;
      end
      `CHK(TRIPPED_O, v)
      if (TRIPPED_O !== v) begin
         final_report();
      end
   endtask

   // Buttons are held long enough to pass the pin synchroniser.
   task automatic pulse_btn(logic confirm);
      @(posedge CLK_I);
      if (confirm) begin
         CONFIRM_BTN_I <= 1'b1;
      end else begin
         CLR_BTN_I <= 1'b1;
      end
      repeat (8) @(posedge CLK_I);
      CLR_BTN_I <= 1'b0;
      CONFIRM_BTN_I <= 1'b0;
      repeat (8) @(posedge CLK_I);
   endtask

   task automatic clr(int src);
      case (src)
         0: begin
            @(posedge CLK_I);
            REMOTE_CLR_I <= 1'b1;
            @(posedge CLK_I);
            REMOTE_CLR_I <= 1'b0;
         end
         1: wr(REG_CTRL, ctrl_v | 16'h0002);
         default: pulse_btn(1'b0);
      endcase
   endtask

   initial begin
      repeat (3) @(posedge CLK_I);
      RST_I <= 1'b0;
      #1;
      `CHK({TRIPPED_O, SAFETY_OUT_O, MAIN_OUT_O, IRQ_O}, 4'h8)
      rd(REG_SETPOINT);
      `CHK(rd_val, {4'h0, SP_RESET})
      rd(REG_IRQ_MASK);
      `CHK(rd_val, 16'h0000)
      rd(4'hF);
      `CHK(rd_val, 16'h0000)
      wr(REG_IRQ_MASK, 16'h000F);
      clr(0);
      wait_trip(1'b0);
      repeat (40) begin
         t = sp - 12'h008 + 12'($random(seed) & 15);
         c = 1'($random(seed));
         apply(t, 4'h0, c);
         `CHK(SAFETY_OUT_O, exp_safe(t, sp, 4'h0))
         `CHK(MAIN_OUT_O, c & exp_safe(t, sp, 4'h0))
         if (t >= sp) begin
            wait_trip(1'b1);
            apply(12'h010, 4'h0, 1'b1);
            clr($random(seed) & 3);
            wait_trip(1'b0);
         end
      end
      for (int f = 0; f < 4; f++) begin
         rd(REG_IRQ_STAT);
         apply(12'h010, 4'h1 << f, 1'b1);
         `CHK({SAFETY_OUT_O, MAIN_OUT_O}, 2'b00)
         wait_trip(1'b1);
         `CHK(IRQ_O, 1'b1)
         clr(f % 3);
         repeat (3) @(posedge CLK_I);
         #1;
         `CHK(TRIPPED_O, 1'b1)
         apply(12'h010, 4'h0, 1'b1);
         clr(f % 3);
         wait_trip(1'b0);
         rd(REG_IRQ_STAT);
         `CHK(rd_val[IRQ_W-1:0], 4'h3)
         `CHK(IRQ_O, 1'b0)
      end
      wr(REG_IRQ_MASK, 16'h0000);
      ctrl_v = 16'h0001;
      wr(REG_CTRL, ctrl_v);
      load <= 1'b0;
      apply(sp, 4'h0, 1'b1);
      wait_trip(1'b1);
      `CHK(IRQ_O, 1'b0)
      apply(12'h010, 4'h0, 1'b1);
      wait_trip(1'b0);
      load <= 1'b1;
      repeat (3) @(posedge CLK_I);
      apply(sp + 12'h001, 4'h0, 1'b1);
      wait_trip(1'b1);
      apply(12'h010, 4'h0, 1'b1);
      repeat (10) @(posedge CLK_I);
      #1;
      `CHK(TRIPPED_O, 1'b1)
      rd(REG_STATUS);
      `CHK(rd_val[ST_CURFLAG_BIT], 1'b1)
      clr(0);
      wait_trip(1'b0);
      rd(REG_STATUS);
      `CHK(rd_val[ST_CURFLAG_BIT], 1'b0)
      t = 12'h040 + 12'($random(seed) & 127);
      wr(REG_SP_ENTRY, {4'h0, t});
      pulse_btn(1'b1);
      rd(REG_SETPOINT);
      `CHK(rd_val, {4'h0, t})
      sp = t;
      wr(REG_SP_ENTRY, {4'h0, t + 12'h010});
      repeat (60) @(posedge CLK_I);
      pulse_btn(1'b1);
      rd(REG_SETPOINT);
      `CHK(rd_val, {4'h0, sp})
      apply(sp - 12'h001, 4'h0, 1'b1);
      `CHK(SAFETY_OUT_O, 1'b1)
      `CHK(MAIN_OUT_O, 1'b1)
      apply(sp, 4'h0, 1'b1);
      `CHK({SAFETY_OUT_O, MAIN_OUT_O}, 2'b00)
      wait_trip(1'b1);
      final_report();
   end
endmodule
`default_nettype wire
